// ===== core/srm_monitor.sv
/*
  Slave registration monitor: compares joined slaves against expected-slave
  maps, times the joining window and reports completion and errors.
  Assumes node presence inputs arrive from the network logic asynchronously
  and are synchronised here; registers are reached by a simple word port.
*/
`timescale 1ns/1ps
`default_nettype none
module srm_monitor #(
  parameter int TICK_CYCLES = srm_pkg::SRM_TICK_CYCLES,
  parameter int NODES       = 16
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // Register port
  input  wire srm_pkg::srm_req_s    req_in,
  output logic [15:0]               rdata_out,
  // Network side
  input  wire srm_pkg::srm_nodes_s  nodes_in,
  input  wire logic                 comm_stopped_in,
  // Status
  output logic                      done_out,
  output logic                      error_out
);

  srm_pkg::srm_nodes_s nodes_meta_r;
  srm_pkg::srm_nodes_s nodes_r;
  logic                stop_meta_r;
  logic                stop_r;
  logic [15:0]         out_map_r;
  logic [15:0]         in_map_r;
  logic [15:0]         time_r;
  logic [15:0]         elapsed_r;
  srm_pkg::srm_state_e state_r;
  logic                done_r;
  logic                expired_r;
  logic [15:0]         out_miss_r;
  logic [15:0]         in_miss_r;
  logic [15:0]         out_unexp_r;
  logic [15:0]         in_unexp_r;
  logic                unexp_r;
  logic                stopped_r;
  logic                tick;
  logic [15:0]         out_absent;
  logic [15:0]         in_absent;
  logic [15:0]         out_extra;
  logic [15:0]         in_extra;
  logic                all_joined;
  logic                any_expected;
  logic                missing;
  logic [15:0]         status;

  srm_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .tick_out (tick)
  );

  // Presence is asynchronous to this clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      nodes_meta_r <= '0;
      nodes_r      <= '0;
      stop_meta_r  <= 1'b0;
      stop_r       <= 1'b0;
    end else begin
      nodes_meta_r <= nodes_in;
      nodes_r      <= nodes_meta_r;
      stop_meta_r  <= comm_stopped_in;
      stop_r       <= stop_meta_r;
    end
  end

  // Per-node comparison
  genvar n;
  generate
    for (n = 0; n < NODES; n++) begin : g_node
      assign in_absent[n]  = in_map_r[n] & ~nodes_r.in_nodes[n];
      assign out_absent[n] = out_map_r[n] & ~nodes_r.out_nodes[n];
      assign in_extra[n]   = ~in_map_r[n] & nodes_r.in_nodes[n];
      assign out_extra[n]  = ~out_map_r[n] & nodes_r.out_nodes[n];
    end
  endgenerate

  assign all_joined   = (in_absent == 16'h0000) && (out_absent == 16'h0000);
  assign any_expected = (in_map_r != 16'h0000) || (out_map_r != 16'h0000);
  assign missing      = expired_r && !all_joined;

  // Register writes; reserved word is ignored
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_map_r <= srm_pkg::SRM_RST_MAP;
      in_map_r  <= srm_pkg::SRM_RST_MAP;
      time_r    <= srm_pkg::SRM_RST_TIME;
    end else if (req_in.wr) begin
      case (req_in.addr)
        srm_pkg::SRM_OFF_OUT_MAP: out_map_r <= req_in.wdata;
        srm_pkg::SRM_OFF_IN_MAP:  in_map_r  <= req_in.wdata;
        // Values above the top of range are clamped
        srm_pkg::SRM_OFF_WATCH_TIME: begin
          time_r <= (req_in.wdata > srm_pkg::SRM_TIME_MAX) ? srm_pkg::SRM_TIME_MAX : req_in.wdata;
        end
        default: ;
      endcase
    end
  end

  // Watch window from reset, judged on ticks only
  // Software thus has one time unit after reset to load maps and time
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r   <= srm_pkg::SRM_ST_WAIT;
      elapsed_r <= 16'h0000;
      expired_r <= 1'b0;
    end else begin
      case (state_r)
        srm_pkg::SRM_ST_WAIT: begin
          state_r <= srm_pkg::SRM_ST_WATCH;
        end
        srm_pkg::SRM_ST_WATCH: begin
          if (tick) begin
            elapsed_r <= elapsed_r + 16'h0001;
            if ((elapsed_r + 16'h0001) >= time_r) begin
              expired_r <= 1'b1;
              state_r   <= srm_pkg::SRM_ST_DONE;
            end
          end
        end
        srm_pkg::SRM_ST_DONE: ;
        default: state_r <= srm_pkg::SRM_ST_WAIT;
      endcase
    end
  end

  // Completion: in window only, sticky until reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_r <= 1'b0;
    end else if (!expired_r && (state_r == srm_pkg::SRM_ST_WATCH) && all_joined && any_expected) begin
      done_r <= 1'b1;
    end
  end

  // Missing words follow live presence after expiry
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_miss_r <= 16'h0000;
      in_miss_r  <= 16'h0000;
    end else if (expired_r) begin
      out_miss_r <= out_absent;
      in_miss_r  <= in_absent;
    end
  end

  // Unexpected nodes are latched, never cleared by software
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_unexp_r <= 16'h0000;
      in_unexp_r  <= 16'h0000;
      unexp_r     <= 1'b0;
      stopped_r   <= 1'b0;
    end else begin
      out_unexp_r <= out_unexp_r | out_extra;
      in_unexp_r  <= in_unexp_r | in_extra;
      unexp_r     <= unexp_r | (|out_extra) | (|in_extra);
      stopped_r   <= stopped_r | stop_r;
    end
  end

  always_comb begin
    status                              = 16'h0000;
    status[srm_pkg::SRM_BIT_DONE]       = done_r;
    status[srm_pkg::SRM_BIT_MISSING]    = missing;
    status[srm_pkg::SRM_BIT_UNEXP]      = unexp_r;
    status[srm_pkg::SRM_BIT_STOPPED]    = stopped_r;
    status[srm_pkg::SRM_BIT_ERROR]      = missing | unexp_r | stopped_r;
  end

  // Read data and status pins registered
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
      done_out  <= 1'b0;
      error_out <= 1'b0;
    end else begin
      done_out  <= done_r;
      error_out <= status[srm_pkg::SRM_BIT_ERROR];
      if (req_in.rd) begin
        case (req_in.addr)
          srm_pkg::SRM_OFF_OUT_MAP:     rdata_out <= out_map_r;
          srm_pkg::SRM_OFF_IN_MAP:      rdata_out <= in_map_r;
          srm_pkg::SRM_OFF_WATCH_TIME:  rdata_out <= time_r;
          srm_pkg::SRM_OFF_STATUS:      rdata_out <= status;
          srm_pkg::SRM_OFF_OUT_MISSING: rdata_out <= out_miss_r;
          srm_pkg::SRM_OFF_IN_MISSING:  rdata_out <= in_miss_r;
          srm_pkg::SRM_OFF_OUT_UNEXP:   rdata_out <= out_unexp_r;
          srm_pkg::SRM_OFF_IN_UNEXP:    rdata_out <= in_unexp_r;
          default:                      rdata_out <= 16'h0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== core/srm_pkg.sv
/*
  Package for the slave registration monitor: register offsets, status bit
  positions, reset values and timing constants.
  Assumes a single 100 MHz clock domain.
*/
package srm_pkg;

  // Register word offsets
  localparam logic [3:0] SRM_OFF_OUT_MAP     = 4'h0;
  localparam logic [3:0] SRM_OFF_IN_MAP      = 4'h1;
  localparam logic [3:0] SRM_OFF_WATCH_TIME  = 4'h2;
  localparam logic [3:0] SRM_OFF_RESERVED    = 4'h3;
  localparam logic [3:0] SRM_OFF_STATUS      = 4'h4;
  localparam logic [3:0] SRM_OFF_OUT_MISSING = 4'h6;
  localparam logic [3:0] SRM_OFF_IN_MISSING  = 4'h7;
  localparam logic [3:0] SRM_OFF_OUT_UNEXP   = 4'h8;
  localparam logic [3:0] SRM_OFF_IN_UNEXP    = 4'h9;

  // Status word bit positions
  localparam int SRM_BIT_DONE    = 0;
  localparam int SRM_BIT_MISSING = 8;
  localparam int SRM_BIT_UNEXP   = 9;
  localparam int SRM_BIT_STOPPED = 10;
  localparam int SRM_BIT_ERROR   = 15;

  // Reset values and watch time upper limit
  localparam logic [15:0] SRM_RST_MAP  = 16'h0000;
  localparam logic [15:0] SRM_RST_TIME = 16'h0000;
  localparam logic [15:0] SRM_TIME_MAX = 16'hffdc;

  // Watch word counts 1 ms units by default
  localparam int SRM_TIME_UNIT_NS   = 1000000;
  localparam int SRM_CLK_PERIOD_NS  = 10;
  localparam int SRM_TICK_CYCLES    = SRM_TIME_UNIT_NS / SRM_CLK_PERIOD_NS;

  // Register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } srm_req_s;

  // Node presence from the network side
  typedef struct packed {
    logic [15:0] out_nodes;
    logic [15:0] in_nodes;
  } srm_nodes_s;

  typedef enum logic [2:0] {
    SRM_ST_WAIT  = 3'b001,
    SRM_ST_WATCH = 3'b010,
    SRM_ST_DONE  = 3'b100
  } srm_state_e;

endpackage

// ===== core/srm_tick.sv
/*
  Time-unit tick generator for the watch timer.
  Assumes clk_in at 100 MHz and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module srm_tick #(
  parameter int TICK_CYCLES = srm_pkg::SRM_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Tick
  output logic      tick_out
);

  logic [31:0] cnt_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r    <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (cnt_r == 32'(TICK_CYCLES - 1)) begin
      cnt_r    <= 32'h0000_0000;
      tick_out <= 1'b1;
    end else begin
      cnt_r    <= cnt_r + 32'h0000_0001;
      tick_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== verif/srm_monitor_sva.sv
/* Checker for the slave registration monitor ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module srm_monitor_chk (
  // Clock and reset
  input wire logic                clk_in,
  input wire logic                rst_in,
  // Register port
  input wire srm_pkg::srm_req_s   req_in,
  input wire logic [15:0]         rdata_out,
  // Status
  input wire logic                done_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence st_rd;
    req_in.rd && req_in.addr == 4'h4;
  endsequence
  sequence rd_of(logic [3:0] a);
    req_in.rd && !req_in.wr && req_in.addr == a;
  endsequence
  sequence big_time_wr;
    req_in.wr && req_in.addr == 4'h2 && req_in.wdata > 16'hffdc;
  endsequence
  done_held_a: assert property (done_out |=> done_out) else $error("done dropped");
  read_hold_a: assert property (!req_in.rd |=> $stable(rdata_out)) else $error("read data moved");
  summary_bit_a: assert property (st_rd |=> rdata_out[15] == |rdata_out[10:8])
    else $error("summary bit wrong");
  reserved_zero_a: assert property (st_rd |=> rdata_out[14:11] == 4'h0 && rdata_out[7:1] == 7'h00)
    else $error("reserved status bits set");
  unmapped_zero_a: assert property (req_in.rd && (req_in.addr == 4'h3 || req_in.addr == 4'h5
    || req_in.addr > 4'h9) |=> rdata_out == 16'h0000) else $error("unmapped read not zero");
  time_clamp_a: assert property (big_time_wr ##1 !req_in.wr ##1 rd_of(4'h2) |=> rdata_out == 16'hffdc)
    else $error("time not clamped");
  map_back_a: assert property ((req_in.wr && req_in.addr == 4'h1) ##1 !req_in.wr ##1 rd_of(4'h1)
    |=> rdata_out == $past(req_in.wdata, 3)) else $error("map readback wrong");
  unexp_kept_a: assert property (st_rd ##1 rdata_out[9] ##1 st_rd |=> rdata_out[9])
    else $error("unexpected flag lost");
endmodule
bind srm_monitor srm_monitor_chk chk (.clk_in, .rst_in, .req_in, .rdata_out, .done_out);
`default_nettype wire

// ===== verif/srm_slave_net.sv
/* Model of slaves joining and leaving the network.
   Assumes the bench sets the wanted node sets and a join lag. */
`timescale 1ns/1ps
`default_nettype none
module srm_slave_net (
  // Clock
  input wire logic                  clk_in,
  // Wanted presence and lag
  input wire logic [15:0]           want_out_in,
  input wire logic [15:0]           want_in_in,
  input wire logic [7:0]            lag_in,
  // Presence seen by the master
  output wire srm_pkg::srm_nodes_s  nodes_out
);
  srm_pkg::srm_nodes_s seen_r = '0;
  logic [7:0]          wait_r = 8'h00;
  assign nodes_out = seen_r;
  // Slaves come up some time after power, not at once
  always @(posedge clk_in) begin
    if ({want_out_in, want_in_in} == seen_r) wait_r <= 8'h00;
    else if (wait_r >= lag_in) seen_r <= {want_out_in, want_in_in};
    else wait_r <= wait_r + 8'h01;
  end
endmodule
`default_nettype wire

// ===== verif/srm_monitor_test.sv
/* Bench for the slave registration monitor with a slave network model.
   Assumes 100 MHz and a 4-cycle time unit to keep runs short. */
`timescale 1ns/1ps
`default_nettype none
module srm_monitor_test;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } srm_row_s;
  logic                clk_in = 1'b0;
  logic                rst_in = 1'b1;
  logic                comm_stopped_in = 1'b0;
  logic [15:0]         want_out = '0;
  logic [15:0]         want_in = '0;
  logic [7:0]          lag = '0;
  logic [15:0]         rdata_out;
  logic                done_out;
  logic                error_out;
  srm_pkg::srm_req_s   req_in = '0;
  srm_pkg::srm_nodes_s nodes;
  int                  fails = 0;
  int                  n_checks = 0;
  srm_row_s            rows [8] = '{'{4'h1, 16'ha5a5, 16'ha5a5}, '{4'h2, 16'hffff, 16'hffdc},
    '{4'h2, 16'hffdd, 16'hffdc}, '{4'h2, 16'hffdc, 16'hffdc}, '{4'h2, 16'h0001, 16'h0001},
    '{4'h3, 16'h1234, 16'h0000}, '{4'h5, 16'h5555, 16'h0000}, '{4'hf, 16'hffff, 16'h0000}};
  always #5 clk_in = ~clk_in;
  srm_monitor #(.TICK_CYCLES(4)) uut (.clk_in, .rst_in, .req_in, .rdata_out, .nodes_in(nodes),
    .comm_stopped_in, .done_out, .error_out);
  srm_slave_net net (.clk_in, .want_out_in(want_out), .want_in_in(want_in), .lag_in(lag), .nodes_out(nodes));
  task automatic complete_run();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk1(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req_in <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_in);
    req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_in);
    req_in <= '0;
    #1 chk16("rdata", e, rdata_out);
  endtask
  // Slaves drop with reset so none looks unexpected later
  task automatic restart();
    @(posedge clk_in);
    rst_in <= 1'b1;
    want_out <= '0;
    want_in <= '0;
    lag <= '0;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_in);
      if (done_out === 1'b1) return;
    end
    fails++;
    complete_run();
  endtask
  initial begin
    restart();
    for (logic [3:0] a = 4'h0; a < 4'h5; a++) if (a != 4'h3) rd(a, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp);
    end
    $display("test registers done");
    restart();
    wr(4'h2, 16'h0064);
    wr(4'h1, 16'h0003);
    lag <= 8'd20;
    want_in <= 16'h0003;
    want_out <= 16'h0020;
    wait_done();
    rd(4'h4, 16'h8201);
    rd(4'h8, 16'h0020);
    want_out <= 16'h0000;
    repeat (30) @(posedge clk_in);
    rd(4'h4, 16'h8201);
    rd(4'h4, 16'h8201);
    repeat (450) @(posedge clk_in);
    #1 chk1("done", 1'b1, done_out);
    chk1("error", 1'b1, error_out);
    $display("test completion done");
    restart();
    wr(4'h2, 16'h000a);
    wr(4'h1, 16'h8001);
    want_in <= 16'h0001;
    rd(4'h4, 16'h0000);
    repeat (60) @(posedge clk_in);
    rd(4'h4, 16'h8100);
    rd(4'h7, 16'h8000);
    want_in <= 16'h8001;
    repeat (5) @(posedge clk_in);
    rd(4'h4, 16'h0000);
    chk1("error", 1'b0, error_out);
    chk1("done", 1'b0, done_out);
    $display("test missing done");
    restart();
    wr(4'h2, 16'h0002);
    repeat (20) @(posedge clk_in);
    rd(4'h4, 16'h0000);
    @(posedge clk_in);
    comm_stopped_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    comm_stopped_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd(4'h4, 16'h8400);
    $display("test empty map done");
    complete_run();
  end
endmodule
`default_nettype wire
